/* bsfs_pkg.sv */
// Purpose: constants for the buck start-up and fault sequencer
// Assumes: core_clk is the 10 MHz internal timebase
// Notes: cycle counts derive from times in ns
package bsfs_pkg;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int BLANK_TIME_NS = 160;
    // least time: round up
    localparam int BLANK_CYC = (BLANK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] BLANK_CYC_W = 4'(BLANK_CYC);
    localparam int HICCUP_CYCLES = 4096;
    localparam logic [12:0] HICCUP_CYC_W = 13'h1000;

    // ----------------------------------------
    // switching period and pre-bias steps
    // ----------------------------------------
    localparam logic [5:0] PERIOD_LAST = 6'h13;
    localparam logic [5:0] LOW_MIN = 6'h01;
    localparam logic [5:0] STEP1_PULSES = 6'h20;
    localparam logic [5:0] STEP2_PULSES = 6'h10;
    localparam logic [5:0] STEP3_PULSES = 6'h08;
    localparam logic [2:0] DUTY_Q1 = 3'h1;
    localparam logic [2:0] DUTY_FULL = 3'h4;

    // ----------------------------------------
    // sequencer states
    // ----------------------------------------
    typedef enum logic [2:0] {
        ST_OFF = 3'b000,
        ST_TRISTATE = 3'b001,
        ST_ASYNC = 3'b010,
        ST_RAMP = 3'b011,
        ST_RUN = 3'b100,
        ST_SSDOWN = 3'b101,
        ST_HICCUP = 3'b110
    } bsfs_state_type;

endpackage

/* bsfs_sequencer.sv */
// Purpose: start-up, pre-bias, pwm gating and fault sequencing of a buck controller
// Assumes: comparator levels arrive unsynchronised; duty word from the loop is sync
// Notes: gate commands are registered; tristate is a separate enable output
//
// Overview of operation
// - drives off when supply or enable low
// - ready flag needs supply and enable (turn-on level only while off), starts soft-start
// - start only with enable above turn-on threshold
// - low side off until first high pulse
// - low pulse steps 25, 50, 75, 100 percent
// - steps last 32, 16, 8 pulses
// - overcurrent trip active during soft-start ramp
// - soft-start node low forces low side on
// - soft-start shutdown left only by node cycling
// - enable below shutdown level tristates drivers
// - high pulse starts at cycle edge, comparator ends
// - sync rising edge locks cycle to sync
// - overcurrent when sense below ground, low on
// - sense ignored 2 cycles (160 ns rounded up to 200 ns) after low rises
// - trip latches, hiccup shorts soft-start node
// - hiccup lasts 4096 switching periods then soft-start
// - hiccup repeats while overload persists
module bsfs_sequencer (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic supply_ok,
    input wire logic enable_on,
    input wire logic enable_above_off,
    input wire logic softstart_low,
    input wire logic sense_below_gnd,
    input wire logic sync_in,
    input wire logic [5:0] duty_cmp,
    output logic high_drive,
    output logic low_drive,
    output logic drive_enable,
    output logic supply_valid_flag,
    output logic softstart_discharge,
    output logic overcurrent_trip,
    output logic sync_locked
);

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    logic [5:0] meta_r;
    logic [5:0] sync_r;
    logic [5:0] raw;
    assign raw = {sync_in, sense_below_gnd, softstart_low, enable_above_off, enable_on, supply_ok};

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            meta_r <= 6'h00;
            sync_r <= 6'h00;
        end
        else
        begin
            meta_r <= raw;
            sync_r <= meta_r;
        end
    end

    logic s_supply, s_en_on, s_en_hold, s_ss_low, s_sense, s_sync;
    assign s_supply = sync_r[0];
    assign s_en_on = sync_r[1];
    assign s_en_hold = sync_r[2];
    assign s_ss_low = sync_r[3];
    assign s_sense = sync_r[4];
    assign s_sync = sync_r[5];

    // ----------------------------------------
    // sequencer state
    // ----------------------------------------
    bsfs_pkg::bsfs_state_type state_r, state_nxt;
    logic [5:0] phase_r, phase_nxt;
    logic [5:0] pulses_r, pulses_nxt;
    logic [2:0] duty_r, duty_nxt;
    logic [12:0] hic_r, hic_nxt;
    logic [3:0] blank_r, blank_nxt;
    logic sync_prev_r, sync_prev_nxt;
    logic locked_r, locked_nxt;
    logic trip_r, trip_nxt;
    logic ss_seen_r, ss_seen_nxt;
    logic hi_r, hi_nxt;
    logic lo_r, lo_nxt;
    logic en_r, en_nxt;
    logic ready_r, ready_nxt;
    logic dis_r, dis_nxt;

    logic ready;
    logic cycle_start;
    logic sync_edge;
    logic [7:0] low_width;
    logic low_on;
    logic oc_event;

    // turn-on needs the higher enable level; hysteresis holds until the 1 V level
    assign ready = s_supply && s_en_hold && (s_en_on || state_r != bsfs_pkg::ST_OFF);
    assign sync_edge = s_sync && !sync_prev_r;
    // once locked, the sync edge replaces the free-running terminal count
    assign cycle_start = locked_r ? sync_edge : (phase_r == bsfs_pkg::PERIOD_LAST);
    // low pulse fills the off time scaled by duty_r quarters
    assign low_width = 8'((({2'h0, bsfs_pkg::PERIOD_LAST} - {2'h0, duty_cmp}) * duty_r) >> 2);

    always_comb
    begin
        low_on = 1'b0;
        if (phase_r >= duty_cmp)
        begin
            low_on = ({2'h0, phase_r} - {2'h0, duty_cmp}) < low_width;
        end
    end

    // blanking counter expires before the sense comparator is trusted
    assign oc_event = lo_r && (blank_r == 4'h0) && s_sense;

    always_comb
    begin
        state_nxt = state_r;
        phase_nxt = cycle_start ? 6'h00 : phase_r + 6'h01;
        pulses_nxt = pulses_r;
        duty_nxt = duty_r;
        hic_nxt = hic_r;
        blank_nxt = blank_r;
        sync_prev_nxt = s_sync;
        locked_nxt = locked_r || sync_edge;
        trip_nxt = trip_r;
        ss_seen_nxt = ss_seen_r;
        hi_nxt = 1'b0;
        lo_nxt = 1'b0;
        en_nxt = 1'b1;
        ready_nxt = ready;
        dis_nxt = 1'b0;
        if (lo_r && blank_r != 4'h0)
        begin
            blank_nxt = blank_r - 4'h1;
        end
        else if (!lo_r)
        begin
            blank_nxt = bsfs_pkg::BLANK_CYC_W;
        end
        if (phase_r > bsfs_pkg::PERIOD_LAST && !locked_r)
        begin
            phase_nxt = 6'h00;
        end

        case (state_r)
            bsfs_pkg::ST_OFF:
            begin
                hi_nxt = 1'b0;
                lo_nxt = 1'b0;
                en_nxt = s_en_hold;
                if (ready)
                begin
                    state_nxt = bsfs_pkg::ST_ASYNC;
                    duty_nxt = bsfs_pkg::DUTY_Q1;
                    pulses_nxt = bsfs_pkg::STEP1_PULSES;
                end
            end
            bsfs_pkg::ST_TRISTATE:
            begin
                en_nxt = 1'b0;
                if (s_en_hold)
                begin
                    state_nxt = bsfs_pkg::ST_OFF;
                end
            end
            bsfs_pkg::ST_ASYNC, bsfs_pkg::ST_RAMP, bsfs_pkg::ST_RUN:
            begin
                // trailing edge: rise at boundary, fall at comparison
                hi_nxt = (phase_nxt < duty_cmp);
                if (state_r != bsfs_pkg::ST_ASYNC)
                begin
                    lo_nxt = !hi_nxt && low_on;
                end
                if (state_r == bsfs_pkg::ST_ASYNC && hi_r)
                begin
                    state_nxt = bsfs_pkg::ST_RAMP;
                end
                if (state_r == bsfs_pkg::ST_RAMP && cycle_start)
                begin
                    if (pulses_r > bsfs_pkg::LOW_MIN)
                    begin
                        pulses_nxt = pulses_r - 6'h01;
                    end
                    else
                    begin
                        duty_nxt = duty_r + 3'h1;
                        if (duty_r == 3'h1)
                        begin
                            pulses_nxt = bsfs_pkg::STEP2_PULSES;
                        end
                        else
                        begin
                            pulses_nxt = bsfs_pkg::STEP3_PULSES;
                        end
                        if (duty_nxt == bsfs_pkg::DUTY_FULL)
                        begin
                            state_nxt = bsfs_pkg::ST_RUN;
                        end
                    end
                end
                if (oc_event)
                begin
                    trip_nxt = 1'b1;
                    hic_nxt = 13'h0000;
                    state_nxt = bsfs_pkg::ST_HICCUP;
                    hi_nxt = 1'b0;
                    lo_nxt = 1'b0;
                end
                else if (s_ss_low)
                begin
                    state_nxt = bsfs_pkg::ST_SSDOWN;
                    ss_seen_nxt = 1'b1;
                    hi_nxt = 1'b0;
                    lo_nxt = 1'b0;
                end
            end
            bsfs_pkg::ST_SSDOWN:
            begin
                hi_nxt = 1'b0;
                lo_nxt = 1'b1;
                // leave only after node was low and is released
                if (!s_ss_low && ss_seen_r)
                begin
                    ss_seen_nxt = 1'b0;
                    state_nxt = bsfs_pkg::ST_ASYNC;
                    duty_nxt = bsfs_pkg::DUTY_Q1;
                    pulses_nxt = bsfs_pkg::STEP1_PULSES;
                    lo_nxt = 1'b0;
                end
            end
            bsfs_pkg::ST_HICCUP:
            begin
                dis_nxt = 1'b1;
                if (cycle_start)
                begin
                    hic_nxt = hic_r + 13'h0001;
                end
                if (hic_r == bsfs_pkg::HICCUP_CYC_W)
                begin
                    trip_nxt = 1'b0;
                    dis_nxt = 1'b0;
                    state_nxt = bsfs_pkg::ST_ASYNC;
                    duty_nxt = bsfs_pkg::DUTY_Q1;
                    pulses_nxt = bsfs_pkg::STEP1_PULSES;
                end
            end
            default:
            begin
                state_nxt = bsfs_pkg::ST_OFF;
            end
        endcase

        // lockout and shutdown override every state
        if (!s_en_hold)
        begin
            state_nxt = bsfs_pkg::ST_TRISTATE;
            en_nxt = 1'b0;
            hi_nxt = 1'b0;
            lo_nxt = 1'b0;
            dis_nxt = 1'b0;
            trip_nxt = 1'b0;
        end
        else if (!ready)
        begin
            state_nxt = bsfs_pkg::ST_OFF;
            hi_nxt = 1'b0;
            lo_nxt = 1'b0;
            dis_nxt = 1'b0;
            trip_nxt = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_r <= bsfs_pkg::ST_OFF;
            phase_r <= 6'h00;
            pulses_r <= 6'h00;
            duty_r <= 3'h0;
            hic_r <= 13'h0000;
            blank_r <= 4'h0;
            sync_prev_r <= 1'b0;
            locked_r <= 1'b0;
            trip_r <= 1'b0;
            ss_seen_r <= 1'b0;
            hi_r <= 1'b0;
            lo_r <= 1'b0;
            en_r <= 1'b0;
            ready_r <= 1'b0;
            dis_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            phase_r <= phase_nxt;
            pulses_r <= pulses_nxt;
            duty_r <= duty_nxt;
            hic_r <= hic_nxt;
            blank_r <= blank_nxt;
            sync_prev_r <= sync_prev_nxt;
            locked_r <= locked_nxt;
            trip_r <= trip_nxt;
            ss_seen_r <= ss_seen_nxt;
            hi_r <= hi_nxt;
            lo_r <= lo_nxt;
            en_r <= en_nxt;
            ready_r <= ready_nxt;
            dis_r <= dis_nxt;
        end
    end

    assign high_drive = hi_r;
    assign low_drive = lo_r;
    assign drive_enable = en_r;
    assign supply_valid_flag = ready_r;
    assign softstart_discharge = dis_r;
    assign overcurrent_trip = trip_r;
    assign sync_locked = locked_r;

endmodule

/* bsfs_fet_model.sv */
// Purpose: switch pair and sense pin seen by the sequencer
// Assumes: overload is commanded by the bench
// Notes: sense follows the low fet at once, like a comparator
module bsfs_fet_model (
    input wire logic high_drive,
    input wire logic low_drive,
    input wire logic drive_enable,
    input wire logic overload,
    output logic sense_below_gnd
);
    timeunit 1ns;
    timeprecision 1ns;
    // pin only dips below ground while the low fet conducts
    assign sense_below_gnd = overload & drive_enable & low_drive & ~high_drive;
endmodule

/* bsfs_checker.sv */
// Purpose: port-level checks of bsfs_sequencer
// Assumes: inputs settle through a 2-flop synchroniser
// Notes: lockout windows allow 4 cycles of sync delay
module bsfs_checker (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic supply_ok,
    input wire logic enable_on,
    input wire logic enable_above_off,
    input wire logic softstart_low,
    input wire logic sense_below_gnd,
    input wire logic sync_in,
    input wire logic [5:0] duty_cmp,
    input wire logic high_drive,
    input wire logic low_drive,
    input wire logic drive_enable,
    input wire logic supply_valid_flag,
    input wire logic softstart_discharge,
    input wire logic overcurrent_trip,
    input wire logic sync_locked
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);
    sequence s_trip;
        $rose(overcurrent_trip);
    endsequence
    sequence s_quiet;
        !high_drive && !low_drive;
    endsequence
    a_no_overlap: assert property (!(high_drive && low_drive))
        else $error("both drives on");
    a_supply_off: assert property ((!supply_ok)[*4] |-> s_quiet)
        else $error("drive during lockout");
    a_off_tristate: assert property ((!enable_above_off)[*4] |-> !drive_enable)
        else $error("drivers not tristated");
    a_ready_cause: assert property ($rose(supply_valid_flag) |-> $past(supply_ok) && $past(enable_on))
        else $error("ready without inputs");
    a_trip_short: assert property (s_trip |-> ##[0:1] softstart_discharge)
        else $error("no discharge on trip");
    a_hiccup_quiet: assert property (softstart_discharge |-> s_quiet)
        else $error("drive during hiccup");
    a_hiccup_hold: assert property ($rose(softstart_discharge) |=> softstart_discharge[*8])
        else $error("hiccup ended early");
    a_trip_low: assert property (s_trip |-> $past(low_drive) || $past(low_drive, 2) || $past(low_drive, 3))
        else $error("trip with low side off");
endmodule
bind bsfs_sequencer bsfs_checker i_bsfs_checker (.*);

/* test_bsfs_sequencer.sv */
// Purpose: self-checking bench for bsfs_sequencer
// Assumes: duty_cmp fixed at 10 of 20 phases
// Notes: hiccup end is timed against 4096 sync periods of 16 cycles
module test_bsfs_sequencer;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk, arst_n, supply_ok, enable_on, enable_above_off, softstart_low;
    logic sense_below_gnd, sync_in, overload, sync_run;
    logic [5:0] duty_cmp;
    logic [3:0] sync_cnt;
    logic high_drive, low_drive, drive_enable, supply_valid_flag;
    logic softstart_discharge, overcurrent_trip, sync_locked;
    int errors, n_compared;
    bsfs_sequencer i_bsfs_sequencer (.core_clk(core_clk), .arst_n(arst_n),
        .supply_ok(supply_ok), .enable_on(enable_on), .enable_above_off(enable_above_off),
        .softstart_low(softstart_low), .sense_below_gnd(sense_below_gnd),
        .sync_in(sync_in), .duty_cmp(duty_cmp), .high_drive(high_drive),
        .low_drive(low_drive), .drive_enable(drive_enable),
        .supply_valid_flag(supply_valid_flag), .softstart_discharge(softstart_discharge),
        .overcurrent_trip(overcurrent_trip), .sync_locked(sync_locked));
    bsfs_fet_model i_bsfs_fet_model (.high_drive(high_drive), .low_drive(low_drive),
        .drive_enable(drive_enable), .overload(overload), .sense_below_gnd(sense_below_gnd));
    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    // sync period 16 cycles: free run of 20 cycles sits 25 percent above it
    always @(posedge core_clk)
    begin
        sync_cnt <= sync_run ? sync_cnt + 4'h1 : 4'h0;
        sync_in <= sync_cnt[3];
    end
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED t=%0t got %0h want %0h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic bound(input int i, input int n);
        if (i >= n)
        begin
            errors++;
            summarize();
        end
    endtask
    task automatic clks(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    // cycles from one high pulse start to the next
    task automatic rise(output int n);
        int i;
        for (i = 0; i < 40 && high_drive === 1'b1; i++) clks(1);
        for (n = i; n < 80 && high_drive !== 1'b1; n++) clks(1);
        bound(n, 80);
    endtask
    task automatic do_reset();
        @(posedge core_clk);
        arst_n <= 1'b0;
        repeat (6) @(posedge core_clk);
        arst_n <= 1'b1;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_start();
        int i, w, hc, hw, first, last, same;
        @(posedge core_clk);
        supply_ok <= 1'b1;
        enable_on <= 1'b1;
        enable_above_off <= 1'b1;
        for (i = 0; i < 20 && supply_valid_flag !== 1'b1; i++) clks(1);
        bound(i, 20);
        for (i = 0; i < 100 && high_drive !== 1'b1; i++)
        begin
            chk(8'(low_drive), 8'h00);
            clks(1);
        end
        bound(i, 100);
        {w, hc, hw, first, last, same} = '0;
        for (i = 0; i < 1400; i++)
        begin
            clks(1);
            if (high_drive === 1'b1) hc++;
            else if (hc > 0)
            begin
                hw = hc;
                hc = 0;
            end
            if (low_drive === 1'b1) w++;
            else if (w > 0)
            begin
                first = first == 0 ? w : first;
                same += int'(w == first);
                last = w;
                w = 0;
            end
        end
        chk(8'(same), 8'h20);
        chk(8'(last), 8'(bsfs_pkg::PERIOD_LAST) - 8'h0a);
        chk(8'(hw), 8'h0a);
    endtask
    task automatic t_sync();
        int p;
        @(posedge core_clk);
        sync_run <= 1'b1;
        clks(100);
        chk(8'(sync_locked), 8'h01);
        rise(p);
        rise(p);
        chk(8'(p), 8'h10);
    endtask
    task automatic t_ssdown();
        int p;
        @(posedge core_clk);
        softstart_low <= 1'b1;
        clks(8);
        chk(8'({high_drive, low_drive}), 8'h01);
        @(posedge core_clk);
        softstart_low <= 1'b0;
        rise(p);
    endtask
    task automatic t_lock();
        @(posedge core_clk);
        enable_above_off <= 1'b0;
        clks(6);
        chk(8'(drive_enable), 8'h00);
        @(posedge core_clk);
        enable_above_off <= 1'b1;
        supply_ok <= 1'b0;
        clks(6);
        chk(8'({high_drive, low_drive}), 8'h00);
    endtask
    task automatic t_trip();
        int i;
        do_reset();
        @(posedge core_clk);
        supply_ok <= 1'b1;
        enable_on <= 1'b0;
        clks(8);
        chk(8'(supply_valid_flag), 8'h00);
        @(posedge core_clk);
        enable_on <= 1'b1;
        overload <= 1'b1;
        for (i = 0; i < 1500 && overcurrent_trip !== 1'b1; i++) clks(1);
        bound(i, 1500);
        clks(2);
        chk(8'(softstart_discharge), 8'h01);
        clks(500);
        chk(8'({softstart_discharge, high_drive, low_drive}), 8'h04);
        for (i = 0; i < 70000 && overcurrent_trip !== 1'b0; i++) clks(1);
        bound(i, 70000);
        // 4096 sync periods of 16 cycles, at most two periods early; only the loop limit bounds the late side
        chk(8'((i + 534) >> 16), 8'h01);
        for (i = 0; i < 1500 && overcurrent_trip !== 1'b1; i++) clks(1);
        bound(i, 1500);
    endtask
    initial
    begin
        {arst_n, supply_ok, enable_on, enable_above_off, softstart_low} = '0;
        {overload, sync_run} = '0;
        duty_cmp = 6'h0a;
        errors = 0;
        n_compared = 0;
        do_reset();
        clks(1);
        chk(8'({high_drive, low_drive, supply_valid_flag, overcurrent_trip}), 8'h00);
        t_start();
        t_sync();
        t_ssdown();
        t_lock();
        t_trip();
        summarize();
    end
endmodule
